// *** efmb_pkg.sv ***
`default_nettype none
package efmb_pkg;
	// register indices; byte address is four times the index
	localparam logic [5:0] IDX_PEND_MID   = 6'h11;
	localparam logic [5:0] IDX_PEND_HIGH  = 6'h12;
	localparam logic [5:0] IDX_A_LOW      = 6'h14;
	localparam logic [5:0] IDX_A_MID      = 6'h15;
	localparam logic [5:0] IDX_A_HIGH     = 6'h16;
	localparam logic [5:0] IDX_B_LOW      = 6'h18;
	localparam logic [5:0] IDX_B_MID      = 6'h19;
	localparam logic [5:0] IDX_B_HIGH     = 6'h1a;
	localparam logic [5:0] IDX_BIND_INSTR = 6'h1c;
	localparam logic [5:0] IDX_BIND_CTRL  = 6'h1d;
	localparam logic [5:0] IDX_PIN_ROUTE  = 6'h20;
	localparam logic [5:0] IDX_IRQ_STATUS = 6'h21;
	localparam logic [5:0] IDX_IRQ_ENABLE = 6'h22;
	localparam logic [5:0] IDX_IRQ_CLEAR  = 6'h23;

	// reset values
	localparam logic [7:0]  RST_PEND      = 8'h00;
	localparam logic [23:0] RST_SEL       = 24'h000000;
	localparam logic [3:0]  RST_INSTR     = 4'h0;
	localparam logic        RST_BIND_EN   = 1'b0;
	localparam logic [4:0]  RST_BIND_EVT  = 5'h12;
	localparam logic [31:0] RST_ROUTE     = 32'h00000000;
	localparam logic [2:0]  RST_IRQ       = 3'h0;

	// field positions
	localparam int BIND_EN_BIT  = 7;
	localparam int BIND_EVT_MSB = 4;
	localparam int INSTR_MSB    = 3;
	localparam int ROUTE_W      = 4;
	localparam int IRQ_CHAN_A   = 0;
	localparam int IRQ_CHAN_B   = 1;
	localparam int IRQ_BIND     = 2;
	localparam int IRQ_W        = 3;
	localparam int NUM_EXC      = 24;

	// pending bits that exist; bit 7 of the high byte is unused
	localparam logic [7:0]  PEND_MID_IMPL  = 8'hff;
	localparam logic [7:0]  PEND_HIGH_IMPL = 8'h7f;
	localparam logic [23:0] EXC_VALID      = 24'h7fffff;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		ROUTE_OFF   = 3'h0,
		ROUTE_A     = 3'h1,
		ROUTE_B     = 3'h2,
		ROUTE_NOT_A = 3'h3,
		ROUTE_NOT_B = 3'h4
	} efmb_route_e;
endpackage : efmb_pkg
`default_nettype wire

// *** efmb_flag_bank.sv ***
`timescale 1ns/1ps
`default_nettype none
module efmb_flag_bank
	import efmb_pkg::*;
#(
	parameter int          W    = 8,
	parameter logic [W-1:0] IMPL = '1
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic [W-1:0] set_evt,
	input  wire logic         wr_en,
	input  wire logic [W-1:0] wr_data,
	output logic      [W-1:0] flags
);
	logic [W-1:0] flags_reg;
	logic [W-1:0] flags_next;

	genvar i;
	generate
		for (i = 0; i < W; i++)
		begin : g_bit
			always_comb
			begin
				flags_next[i] = flags_reg[i];
				if (wr_en && !wr_data[i])
					flags_next[i] = 1'b0;
				if (set_evt[i] && IMPL[i])
					flags_next[i] = 1'b1;
			end
		end
	endgenerate

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			flags_reg <= RST_PEND[W-1:0];
		else
			flags_reg <= flags_next;
	end

	assign flags = flags_reg;
endmodule : efmb_flag_bank
`default_nettype wire

// *** efmb_exc_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module efmb_exc_ctrl
	import efmb_pkg::*;
#(
	parameter int NUM_PINS = 2
) (
	input  wire logic                aclk,
	input  wire logic                aresetn,
	input  wire logic [7:0]          s_axi_awaddr,
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	output logic [1:0]               s_axi_bresp,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	input  wire logic [7:0]          s_axi_araddr,
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	output logic [31:0]              s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	input  wire logic [23:0]         exc_event,
	output logic [NUM_PINS-1:0]      exc_ind_pin,
	output logic                     instr_strobe,
	output logic [3:0]               bind_x_instr_out,
	output logic                     irq
);
	function automatic logic [5:0] reg_index(input logic [7:0] addr);
		return addr[7:2];
	endfunction : reg_index

	function automatic logic is_mapped(input logic [5:0] idx);
		case (idx)
			IDX_PEND_MID, IDX_PEND_HIGH, IDX_A_LOW, IDX_A_MID, IDX_A_HIGH,
			IDX_B_LOW, IDX_B_MID, IDX_B_HIGH, IDX_BIND_INSTR, IDX_BIND_CTRL,
			IDX_PIN_ROUTE, IDX_IRQ_STATUS, IDX_IRQ_ENABLE, IDX_IRQ_CLEAR:
				return 1'b1;
			default:
				return 1'b0;
		endcase
	endfunction : is_mapped

	function automatic logic route_hit(input logic [2:0] code, input logic [3:0] hits);
		case (code)
			ROUTE_A:     return hits[0];
			ROUTE_B:     return hits[1];
			ROUTE_NOT_A: return hits[2];
			ROUTE_NOT_B: return hits[3];
			default:     return 1'b0;
		endcase
	endfunction : route_hit

	// bus write side
	logic        aw_held_reg;
	logic        aw_held_next;
	logic [5:0]  aw_idx_reg;
	logic [5:0]  aw_idx_next;
	logic        w_held_reg;
	logic        w_held_next;
	logic [31:0] w_data_reg;
	logic [31:0] w_data_next;
	logic [3:0]  w_strb_reg;
	logic [3:0]  w_strb_next;
	logic        bvalid_reg;
	logic        bvalid_next;
	logic [1:0]  bresp_reg;
	logic [1:0]  bresp_next;
	logic        wr_fire;

	// bus read side
	logic        rvalid_reg;
	logic        rvalid_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic [1:0]  rresp_reg;
	logic [1:0]  rresp_next;

	// configuration and state
	logic [23:0]         sel_a_reg;
	logic [23:0]         sel_a_next;
	logic [23:0]         sel_b_reg;
	logic [23:0]         sel_b_next;
	logic [3:0]          instr_reg;
	logic [3:0]          instr_next;
	logic                bind_en_reg;
	logic                bind_en_next;
	logic [4:0]          bind_evt_reg;
	logic [4:0]          bind_evt_next;
	logic [31:0]         route_reg;
	logic [31:0]         route_next;
	logic [IRQ_W-1:0]    irq_stat_reg;
	logic [IRQ_W-1:0]    irq_stat_next;
	logic [IRQ_W-1:0]    irq_en_reg;
	logic [IRQ_W-1:0]    irq_en_next;
	logic [NUM_PINS-1:0] ind_reg;
	logic [NUM_PINS-1:0] ind_next;
	logic                strobe_reg;
	logic                strobe_next;
	logic [3:0]          instr_out_reg;
	logic [3:0]          instr_out_next;

	logic [7:0]  pend_mid;
	logic [7:0]  pend_high;
	logic [23:0] evt;
	logic [3:0]  hits;
	logic        bind_fire;

	assign s_axi_awready = !aw_held_reg && !bvalid_reg;
	assign s_axi_wready  = !w_held_reg && !bvalid_reg;
	assign s_axi_arready = !rvalid_reg;
	assign wr_fire       = aw_held_reg && w_held_reg;

	always_comb
	begin
		aw_held_next = aw_held_reg;
		aw_idx_next  = aw_idx_reg;
		w_held_next  = w_held_reg;
		w_data_next  = w_data_reg;
		w_strb_next  = w_strb_reg;
		bvalid_next  = bvalid_reg;
		bresp_next   = bresp_reg;
		if (s_axi_awvalid && s_axi_awready)
		begin
			aw_held_next = 1'b1;
			aw_idx_next  = reg_index(s_axi_awaddr);
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			w_held_next = 1'b1;
			w_data_next = s_axi_wdata;
			w_strb_next = s_axi_wstrb;
		end
		if (wr_fire)
		begin
			aw_held_next = 1'b0;
			w_held_next  = 1'b0;
			bvalid_next  = 1'b1;
			bresp_next   = is_mapped(aw_idx_reg) ? RESP_OKAY : RESP_SLVERR;
		end
		if (bvalid_reg && s_axi_bready)
			bvalid_next = 1'b0;
	end

	// reads have no side effect; pending flags stay until written
	always_comb
	begin
		rvalid_next = rvalid_reg;
		rdata_next  = rdata_reg;
		rresp_next  = rresp_reg;
		if (s_axi_arvalid && s_axi_arready)
		begin
			rvalid_next = 1'b1;
			rresp_next  = is_mapped(reg_index(s_axi_araddr)) ? RESP_OKAY : RESP_SLVERR;
			rdata_next  = 32'h00000000;
			case (reg_index(s_axi_araddr))
				IDX_PEND_MID:   rdata_next[7:0] = pend_mid;
				IDX_PEND_HIGH:  rdata_next[7:0] = pend_high;
				IDX_A_LOW:      rdata_next[7:0] = sel_a_reg[7:0];
				IDX_A_MID:      rdata_next[7:0] = sel_a_reg[15:8];
				IDX_A_HIGH:     rdata_next[7:0] = sel_a_reg[23:16];
				IDX_B_LOW:      rdata_next[7:0] = sel_b_reg[7:0];
				IDX_B_MID:      rdata_next[7:0] = sel_b_reg[15:8];
				IDX_B_HIGH:     rdata_next[7:0] = sel_b_reg[23:16];
				IDX_BIND_INSTR: rdata_next[INSTR_MSB:0] = instr_reg;
				IDX_BIND_CTRL:
				begin
					rdata_next[BIND_EN_BIT]      = bind_en_reg;
					rdata_next[BIND_EVT_MSB:0]   = bind_evt_reg;
				end
				IDX_PIN_ROUTE:  rdata_next = route_reg;
				IDX_IRQ_STATUS: rdata_next[IRQ_W-1:0] = irq_stat_reg;
				IDX_IRQ_ENABLE: rdata_next[IRQ_W-1:0] = irq_en_reg;
				default:        rdata_next = 32'h00000000;
			endcase
		end
		else if (rvalid_reg && s_axi_rready)
			rvalid_next = 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_reg <= 1'b0;
			aw_idx_reg  <= 6'h00;
			w_held_reg  <= 1'b0;
			w_data_reg  <= 32'h00000000;
			w_strb_reg  <= 4'h0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= RESP_OKAY;
			rvalid_reg  <= 1'b0;
			rdata_reg   <= 32'h00000000;
			rresp_reg   <= RESP_OKAY;
		end
		else
		begin
			aw_held_reg <= aw_held_next;
			aw_idx_reg  <= aw_idx_next;
			w_held_reg  <= w_held_next;
			w_data_reg  <= w_data_next;
			w_strb_reg  <= w_strb_next;
			bvalid_reg  <= bvalid_next;
			bresp_reg   <= bresp_next;
			rvalid_reg  <= rvalid_next;
			rdata_reg   <= rdata_next;
			rresp_reg   <= rresp_next;
		end
	end

	// byte registers live in lane 0 only
	logic lane0_wr;
	assign lane0_wr = wr_fire && w_strb_reg[0];

	efmb_flag_bank #(
		.W    (8),
		.IMPL (PEND_MID_IMPL)
	) u_pend_mid (
		.aclk    (aclk),
		.aresetn (aresetn),
		.set_evt (exc_event[15:8]),
		.wr_en   (lane0_wr && aw_idx_reg == IDX_PEND_MID),
		.wr_data (w_data_reg[7:0]),
		.flags   (pend_mid)
	);

	// high pending byte, bit 7 never set
	efmb_flag_bank #(
		.W    (8),
		.IMPL (PEND_HIGH_IMPL)
	) u_pend_high (
		.aclk    (aclk),
		.aresetn (aresetn),
		.set_evt (exc_event[23:16]),
		.wr_en   (lane0_wr && aw_idx_reg == IDX_PEND_HIGH),
		.wr_data (w_data_reg[7:0]),
		.flags   (pend_high)
	);

	always_comb
	begin
		sel_a_next    = sel_a_reg;
		sel_b_next    = sel_b_reg;
		instr_next    = instr_reg;
		bind_en_next  = bind_en_reg;
		bind_evt_next = bind_evt_reg;
		route_next    = route_reg;
		irq_en_next   = irq_en_reg;
		if (lane0_wr)
		begin
			case (aw_idx_reg)
				IDX_A_LOW:      sel_a_next[7:0]   = w_data_reg[7:0];
				IDX_A_MID:      sel_a_next[15:8]  = w_data_reg[7:0];
				IDX_A_HIGH:     sel_a_next[23:16] = w_data_reg[7:0];
				IDX_B_LOW:      sel_b_next[7:0]   = w_data_reg[7:0];
				IDX_B_MID:      sel_b_next[15:8]  = w_data_reg[7:0];
				IDX_B_HIGH:     sel_b_next[23:16] = w_data_reg[7:0];
				IDX_BIND_INSTR: instr_next = w_data_reg[INSTR_MSB:0];
				IDX_BIND_CTRL:
				begin
					bind_en_next  = w_data_reg[BIND_EN_BIT];
					bind_evt_next = w_data_reg[BIND_EVT_MSB:0];
				end
				IDX_IRQ_ENABLE: irq_en_next = w_data_reg[IRQ_W-1:0];
				default:        sel_a_next = sel_a_reg;
			endcase
		end
		if (wr_fire && aw_idx_reg == IDX_PIN_ROUTE)
		begin
			for (int k = 0; k < 4; k++)
			begin
				if (w_strb_reg[k])
					route_next[k*8 +: 8] = w_data_reg[k*8 +: 8];
			end
		end
	end

	// one hit per channel and its complement
	assign evt  = exc_event & EXC_VALID;
	assign hits = {|(evt & ~sel_b_reg), |(evt & ~sel_a_reg), |(evt & sel_b_reg),
		|(evt & sel_a_reg)};
	assign bind_fire = bind_en_reg && (bind_evt_reg < 5'(NUM_EXC)) && evt[bind_evt_reg];

	genvar p;
	generate
		for (p = 0; p < NUM_PINS; p++)
		begin : g_pin
			always_comb
			begin
				ind_next[p] = route_hit(route_reg[p*ROUTE_W +: 3], hits);
			end
		end
	endgenerate

	// status set wins over a clear in the same cycle
	always_comb
	begin
		irq_stat_next = irq_stat_reg;
		if (lane0_wr && aw_idx_reg == IDX_IRQ_CLEAR)
			irq_stat_next = irq_stat_reg & ~w_data_reg[IRQ_W-1:0];
		if (hits[0])
			irq_stat_next[IRQ_CHAN_A] = 1'b1;
		if (hits[1])
			irq_stat_next[IRQ_CHAN_B] = 1'b1;
		if (bind_fire)
			irq_stat_next[IRQ_BIND] = 1'b1;
		strobe_next    = bind_fire;
		instr_out_next = bind_fire ? instr_reg : instr_out_reg;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sel_a_reg     <= RST_SEL;
			sel_b_reg     <= RST_SEL;
			instr_reg     <= RST_INSTR;
			bind_en_reg   <= RST_BIND_EN;
			bind_evt_reg  <= RST_BIND_EVT;
			route_reg     <= RST_ROUTE;
			irq_stat_reg  <= RST_IRQ;
			irq_en_reg    <= RST_IRQ;
			ind_reg       <= '0;
			strobe_reg    <= 1'b0;
			instr_out_reg <= RST_INSTR;
		end
		else
		begin
			sel_a_reg     <= sel_a_next;
			sel_b_reg     <= sel_b_next;
			instr_reg     <= instr_next;
			bind_en_reg   <= bind_en_next;
			bind_evt_reg  <= bind_evt_next;
			route_reg     <= route_next;
			irq_stat_reg  <= irq_stat_next;
			irq_en_reg    <= irq_en_next;
			ind_reg       <= ind_next;
			strobe_reg    <= strobe_next;
			instr_out_reg <= instr_out_next;
		end
	end

	assign s_axi_bvalid     = bvalid_reg;
	assign s_axi_bresp      = bresp_reg;
	assign s_axi_rvalid     = rvalid_reg;
	assign s_axi_rdata      = rdata_reg;
	assign s_axi_rresp      = rresp_reg;
	assign exc_ind_pin      = ind_reg;
	assign instr_strobe     = strobe_reg;
	assign bind_x_instr_out = instr_out_reg;
	assign irq              = |(irq_stat_reg & irq_en_reg);
endmodule : efmb_exc_ctrl
`default_nettype wire

// *** efmb_exc_ctrl_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module efmb_exc_ctrl_props
	import efmb_pkg::*;
#(
	parameter int NUM_PINS = 2
) (
	input wire logic                aclk,
	input wire logic                aresetn,
	input wire logic [7:0]          s_axi_awaddr,
	input wire logic                s_axi_awvalid,
	input wire logic                s_axi_awready,
	input wire logic [31:0]         s_axi_wdata,
	input wire logic [3:0]          s_axi_wstrb,
	input wire logic                s_axi_wvalid,
	input wire logic                s_axi_wready,
	input wire logic [1:0]          s_axi_bresp,
	input wire logic                s_axi_bvalid,
	input wire logic                s_axi_bready,
	input wire logic [7:0]          s_axi_araddr,
	input wire logic                s_axi_arvalid,
	input wire logic                s_axi_arready,
	input wire logic [31:0]         s_axi_rdata,
	input wire logic [1:0]          s_axi_rresp,
	input wire logic                s_axi_rvalid,
	input wire logic                s_axi_rready,
	input wire logic [23:0]         exc_event,
	input wire logic [NUM_PINS-1:0] exc_ind_pin,
	input wire logic                instr_strobe,
	input wire logic [3:0]          bind_x_instr_out,
	input wire logic                irq
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_write_resp_time: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response not on time");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
		&& $stable(s_axi_bresp)) else $error("write response dropped");
	a_read_time: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data not on time");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
		&& $stable(s_axi_rdata)) else $error("read data dropped");
	a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while data pending");
	a_pin_cause: assert property (exc_ind_pin != '0 |-> $past(exc_event) != 24'h000000)
		else $error("indication without exception");
	a_strobe_cause: assert property (instr_strobe |-> $past(exc_event) != 24'h000000)
		else $error("instruction without exception");
	a_instr_hold: assert property ($past(aresetn) && $changed(bind_x_instr_out) |-> instr_strobe)
		else $error("instruction number moved without strobe");
	a_quiet_pins: assert property (exc_event == 24'h000000
		|=> exc_ind_pin == '0 && !instr_strobe) else $error("indication with no exception");
	a_unused_bit: assert property (exc_event == 24'h800000
		|=> exc_ind_pin == '0 && !instr_strobe) else $error("unused exception bit indicated");
endmodule : efmb_exc_ctrl_props

bind efmb_exc_ctrl efmb_exc_ctrl_props #(.NUM_PINS(NUM_PINS)) u_props (.*);
`default_nettype wire

// *** efmb_host_mon.sv ***
`timescale 1ns/1ps
`default_nettype none
// host side: counts indication cycles seen on each pin
module efmb_host_mon (
	input wire logic       aclk,
	input wire logic       aresetn,
	input wire logic [1:0] exc_ind_pin,
	output logic     [7:0] pin0_hits,
	output logic     [7:0] pin1_hits
);
	logic [7:0] pin0_next;
	logic [7:0] pin1_next;

	always_comb
	begin
		pin0_next = pin0_hits + {7'h0, exc_ind_pin[0]};
		pin1_next = pin1_hits + {7'h0, exc_ind_pin[1]};
	end

	always_ff @(posedge aclk)
	begin
		pin0_hits <= aresetn ? pin0_next : 8'h00;
		pin1_hits <= aresetn ? pin1_next : 8'h00;
	end
endmodule : efmb_host_mon
`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import efmb_pkg::*;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic        s_axi_rready, instr_strobe, irq;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, pin0_hits, pin1_hits, exp0, exp1;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb, bind_x_instr_out;
	logic [1:0]  s_axi_bresp, s_axi_rresp, exc_ind_pin;
	logic [23:0] exc_event;
	int          mismatches, comparisons, cycles;
	logic [5:0]  ridx [10] = '{IDX_PEND_MID, IDX_PEND_HIGH, IDX_A_LOW, IDX_A_MID, IDX_A_HIGH,
		IDX_B_LOW, IDX_B_MID, IDX_B_HIGH, IDX_BIND_INSTR, IDX_BIND_CTRL};
	logic [5:0]  base [2] = '{IDX_A_LOW, IDX_B_LOW};

	efmb_exc_ctrl #(.NUM_PINS(2)) u_dut (.*);
	efmb_host_mon u_mon (.aclk(aclk), .aresetn(aresetn), .exc_ind_pin(exc_ind_pin),
		.pin0_hits(pin0_hits), .pin1_hits(pin1_hits));

	initial
	begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : close_out

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			mismatches++;
			$display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// ready is raised only once valid is seen, so the hold assertions get exercised
	task automatic wr(input logic [5:0] idx, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
		logic a, w, b, bv;
		logic [1:0] r;
		@(posedge aclk);
		s_axi_awaddr <= {idx, 2'b00};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		b = 1'b0;
		while (!b)
		begin
			@(negedge aclk);
			a = s_axi_awvalid && s_axi_awready;
			w = s_axi_wvalid && s_axi_wready;
			bv = s_axi_bvalid;
			b = s_axi_bvalid && s_axi_bready;
			r = s_axi_bresp;
			@(posedge aclk);
			if (a) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
			s_axi_bready <= bv && !b;
		end
		chk({30'h0, r}, {30'h0, er});
	endtask : wr

	task automatic rd(input logic [5:0] idx, input logic [31:0] exp, input logic [1:0] er = RESP_OKAY);
		logic a, b, bv;
		logic [1:0] r;
		logic [31:0] d;
		@(posedge aclk);
		s_axi_araddr <= {idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		b = 1'b0;
		while (!b)
		begin
			@(negedge aclk);
			a = s_axi_arvalid && s_axi_arready;
			bv = s_axi_rvalid;
			b = s_axi_rvalid && s_axi_rready;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (a) s_axi_arvalid <= 1'b0;
			s_axi_rready <= bv && !b;
		end
		chk(d, exp);
		chk({30'h0, r}, {30'h0, er});
	endtask : rd

	// one-cycle exception pulse, then the pins and strobe in the following cycle
	task automatic evt(input logic [23:0] e, input logic [1:0] pins, input logic stb);
		@(posedge aclk);
		exc_event <= e;
		@(posedge aclk);
		exc_event <= 24'h000000;
		@(negedge aclk);
		chk({30'h0, exc_ind_pin}, {30'h0, pins});
		chk({31'h0, instr_strobe}, {31'h0, stb});
		exp0 = exp0 + {7'h0, pins[0]};
		exp1 = exp1 + {7'h0, pins[1]};
	endtask : evt

	always @(posedge aclk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			mismatches++;
			close_out();
		end
	end

	initial
	begin
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h00000000;
		s_axi_wstrb = 4'hf;
		exc_event = 24'h000000;
		{exp0, exp1} = 16'h0000;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 10; i++)
			rd(ridx[i], (i == 9) ? {24'h0, RST_BIND_EN, 2'b00, RST_BIND_EVT} : 32'h0);
		foreach (base[c])
		begin
			wr(base[c], 32'ha5);
			wr(base[c] + 6'h1, 32'h5a);
			wr(base[c] + 6'h2, 32'h3c);
			wr(base[c] + 6'h1, 32'hc3);
			rd(base[c], 32'ha5);
			rd(base[c] + 6'h1, 32'hc3);
			rd(base[c] + 6'h2, 32'h3c);
			wr(base[c], 32'h00);
			wr(base[c] + 6'h1, {30'h0, c[0], !c[0]});
			wr(base[c] + 6'h2, 32'h00);
		end
		// byte registers sit in lane 0, so a write without that strobe must not land
		s_axi_wstrb <= 4'he;
		wr(IDX_A_LOW, 32'hff);
		rd(IDX_A_LOW, 32'h00);
		s_axi_wstrb <= 4'hf;
		wr(IDX_PIN_ROUTE, {24'h0, 1'b0, ROUTE_NOT_A, 1'b0, ROUTE_A});
		evt(24'h000100, 2'b01, 1'b0);
		evt(24'h000200, 2'b10, 1'b0);
		wr(IDX_PIN_ROUTE, {24'h0, 1'b0, ROUTE_NOT_B, 1'b0, ROUTE_B});
		evt(24'h000200, 2'b01, 1'b0);
		evt(24'h000100, 2'b10, 1'b0);
		wr(IDX_BIND_INSTR, 32'hff);
		rd(IDX_BIND_INSTR, 32'h0f);
		wr(IDX_BIND_CTRL, 32'h8a);
		evt(24'h000400, 2'b10, 1'b1);
		chk({28'h0, bind_x_instr_out}, 32'hf);
		evt(24'h000800, 2'b10, 1'b0);
		wr(IDX_BIND_CTRL, 32'h0a);
		evt(24'h000400, 2'b10, 1'b0);
		evt(24'h800000, 2'b00, 1'b0);
		evt(24'hffffff, 2'b11, 1'b0);
		rd(IDX_PEND_MID, 32'hff);
		rd(IDX_PEND_HIGH, 32'h7f);
		wr(IDX_PEND_MID, 32'hff);
		rd(IDX_PEND_MID, 32'hff);
		wr(IDX_PEND_MID, 32'hf0);
		rd(IDX_PEND_MID, 32'hf0);
		wr(IDX_PEND_HIGH, 32'h00);
		rd(IDX_PEND_HIGH, 32'h00);
		wr(6'h3f, 32'h1, RESP_SLVERR);
		rd(6'h3f, 32'h0, RESP_SLVERR);
		rd(IDX_IRQ_STATUS, 32'h7);
		wr(IDX_IRQ_ENABLE, 32'h1);
		@(negedge aclk);
		chk({31'h0, irq}, 32'h1);
		wr(IDX_IRQ_CLEAR, 32'h7);
		@(negedge aclk);
		chk({31'h0, irq}, 32'h0);
		evt(24'h000100, 2'b10, 1'b0);
		chk({31'h0, irq}, 32'h1);
		wr(IDX_IRQ_ENABLE, 32'h0);
		@(negedge aclk);
		chk({31'h0, irq}, 32'h0);
		chk({24'h0, pin0_hits}, {24'h0, exp0});
		chk({24'h0, pin1_hits}, {24'h0, exp1});
		// second reset in mid-run: written state must fall back to reset values
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd(IDX_A_MID, 32'h0);
		rd(IDX_PEND_MID, 32'h0);
		rd(IDX_BIND_CTRL, {24'h0, RST_BIND_EN, 2'b00, RST_BIND_EVT});
		close_out();
	end
endmodule : testbench
`default_nettype wire
